//--- verif/ierr_host.sv
// Host controller model feeding commands into the receive side
`timescale 1ns/100ps
module ierr_host (
   input  wire logic       clock,
   input  wire logic       send,
   input  wire logic [1:0] kind,
   output logic            rx_cmd_push,
   output logic            rx_parity_err,
   output logic            rx_stop_bit_err
);
   // One command per send; kind 0 clean, 1 bad parity, 2 bad stop bit
   always_ff @(posedge clock) begin
      rx_cmd_push     <= send && kind == 2'h0;
      rx_parity_err   <= send && kind == 2'h1;
      rx_stop_bit_err <= send && kind == 2'h2;
   end
endmodule

//--- verif/ierr_reporter_sva.sv
// Concurrent checks on the error reporting unit ports
`timescale 1ns/100ps
module ierr_reporter_chk
   import ierr_pkg::*;
(
   input wire logic             clock,
   input wire logic             rst,
   input wire logic             rx_cmd_push,
   input wire logic             rx_cmd_pop,
   input wire logic             rx_parity_err,
   input wire logic             rx_stop_bit_err,
   input wire logic             servo_on_in,
   input wire logic             fault_in,
   input wire logic             rx_flush,
   input wire logic             rx_cmd_discard,
   input wire logic             error_reply_valid,
   input wire logic [7:0]       error_reply_code,
   input wire logic [7:0]       last_error_code,
   input wire logic             common_error_display_code,
   input wire logic             red_led,
   input wire logic             caution_out,
   input wire logic             fault_out,
   input wire logic             servo_on_out,
   input wire logic [RXQ_W-1:0] rx_cmd_count
);
   logic        err_seen;
   logic [24:0] hold_cnt_r;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Any reported error, replied or silently discarded
   assign err_seen = error_reply_valid || rx_cmd_discard;
   // Cycles since the latest error; saturates so it never wraps
   always_ff @(posedge clock) begin
      if (rst) hold_cnt_r <= 25'h0;
      else if (err_seen) hold_cnt_r <= 25'h1;
      else if (hold_cnt_r != 25'h0 && hold_cnt_r != 25'h1ffffff) hold_cnt_r <= hold_cnt_r + 25'h1;
   end
   hold_set_a: assert property (err_seen |=> caution_out && common_error_display_code)
      else $error("hold outputs not raised after error");
   hold_keep_a: assert property (hold_cnt_r != 0 && hold_cnt_r <= HOLD_CYCLES |-> caution_out)
      else $error("caution dropped inside hold time");
   led_rise_a: assert property ($rose(caution_out) |-> red_led)
      else $error("led off at start of hold");
   servo_pass_a: assert property (!$past(rst) |-> servo_on_out == $past(servo_on_in))
      else $error("servo state altered");
   fault_pass_a: assert property (!$past(rst) |-> fault_out == $past(fault_in))
      else $error("fault output altered");
   reply_code_a: assert property (error_reply_valid |-> error_reply_code == last_error_code)
      else $error("reply code differs from stored code");
   parity_drop_a: assert property (rx_parity_err && !rx_stop_bit_err |=> rx_cmd_discard
      && !error_reply_valid && last_error_code == ERR_PARITY) else $error("parity error mishandled");
   stop_drop_a: assert property (rx_stop_bit_err |=> rx_cmd_discard && !error_reply_valid
      && last_error_code == ERR_FRAMING) else $error("stop bit error mishandled");
   buf_ovf_a: assert property (rx_cmd_push && !rx_cmd_pop && rx_cmd_count == 7'd100
      && !rx_parity_err && !rx_stop_bit_err |=> rx_flush && rx_cmd_count == 7'd0
      && error_reply_code == ERR_RX_OVF) else $error("overflow not flushed");
   buf_max_a: assert property (rx_cmd_count <= 7'd100)
      else $error("buffer count above depth");
   // Main scenarios reached
   cover property (rx_flush);
   cover property (rx_cmd_discard);
   cover property (error_reply_valid && error_reply_code == ERR_JOG_CANCEL);
endmodule

//--- verif/ierr_reporter_test.sv
// Self-checking bench for the error reporting unit
`timescale 1ns/100ps
module ierr_reporter_test;
   import ierr_pkg::*;
   logic clock = 0, rst = 1, nv_write_fail = 0, program_table_start_req = 0;
   logic jog_table_start_req = 0, powerup_alarms_valid = 0, rx_cmd_pop = 0;
   logic servo_on_in = 0, fault_in = 0, send = 0;
   logic [1:0] kind = 2'h0;
   logic [3:0] powerup_alarms = 4'h0;
   ierr_tbl_e nv_write_table = IERR_TBL_NONE;
   logic rx_cmd_push, rx_parity_err, rx_stop_bit_err, program_table_start_ok;
   logic jog_table_start_ok, rx_flush, rx_cmd_discard, error_reply_valid, red_led;
   logic common_error_display_code, caution_out, fault_out, servo_on_out;
   logic [7:0] error_reply_code, last_error_code;
   logic [RXQ_W-1:0] rx_cmd_count;
   int mismatches = 0, check_count = 0;
   ierr_reporter ierr_reporter_inst (.clock, .rst, .nv_write_fail, .nv_write_table,
      .program_table_start_req, .jog_table_start_req, .powerup_alarms, .powerup_alarms_valid,
      .rx_cmd_push, .rx_cmd_pop, .rx_parity_err, .rx_stop_bit_err, .servo_on_in, .fault_in,
      .program_table_start_ok, .jog_table_start_ok, .rx_flush, .rx_cmd_discard,
      .error_reply_valid, .error_reply_code, .last_error_code, .common_error_display_code,
      .red_led, .caution_out, .fault_out, .servo_on_out, .rx_cmd_count);
   ierr_host ierr_host_inst (.clock, .send, .kind, .rx_cmd_push, .rx_parity_err,
      .rx_stop_bit_err);
   // Clock and random servo and fault levels each cycle
   always #50 clock = ~clock;
   always @(posedge clock) begin
      #1;
      servo_on_in = 1'($urandom);
      fault_in = 1'($urandom);
   end
   task tick(int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task check(string what, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One-cycle pulse; returns while the one-cycle registered answer stands
   task automatic pulse(ref logic s);
      s = 1;
      tick();
      s = 0;
   endtask
   // Host registers the frame one edge after send, the design answers one edge later
   task host(logic [1:0] k);
      kind = k;
      send = 1;
      tick();
      send = 0;
      tick();
   endtask
   task expect_reply(logic [7:0] code);
      check("reply valid", error_reply_valid, 8'h1);
      check("reply code", error_reply_code, code);
      check("last code", last_error_code, code);
   endtask
   task expect_hold;
      tick();
      check("caution", caution_out, 8'h1);
      check("display", common_error_display_code, 8'h1);
      check("led", red_led, 8'h1);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog; the whole sequence needs far less
   initial begin
      #200us;
      mismatches++;
      stop_test();
   end
   initial begin
      void'($urandom(45));
      tick(3);
      rst = 0;
      check("last code", last_error_code, 8'h00);
      pulse(program_table_start_req);
      check("pgm ok", program_table_start_ok, 8'h1);
      // Every table, one idle cycle between failures
      for (int i = 0; i < 3; i++) begin
         nv_write_table = ierr_tbl_e'(i);
         pulse(nv_write_fail);
         expect_reply(8'h41 + 8'(i));
         tick();
      end
      expect_hold();
      // Program start blocked by one random power-up alarm, jog still free
      powerup_alarms = 4'h1 << ($urandom % 2);
      pulse(powerup_alarms_valid);
      pulse(jog_table_start_req);
      check("jog ok", jog_table_start_ok, 8'h1);
      pulse(program_table_start_req);
      check("pgm ok", program_table_start_ok, 8'h0);
      expect_reply(8'h44);
      powerup_alarms = 4'h4 << ($urandom % 2);
      pulse(powerup_alarms_valid);
      pulse(jog_table_start_req);
      check("jog ok", jog_table_start_ok, 8'h0);
      expect_reply(8'h46);
      // Line errors: discarded silently but still flagged
      host(2'h1);
      check("discard", rx_cmd_discard, 8'h1);
      check("no reply", error_reply_valid, 8'h0);
      check("last code", last_error_code, 8'h48);
      expect_hold();
      host(2'h2);
      check("discard", rx_cmd_discard, 8'h1);
      check("last code", last_error_code, 8'h49);
      // Flood without waiting: 100 fit, the next one overflows
      kind = 2'h0;
      send = 1;
      tick(100);
      send = 0;
      tick(2);
      check("count", 8'(rx_cmd_count), 8'd100);
      host(2'h0);
      check("flush", rx_flush, 8'h1);
      expect_reply(8'h47);
      check("count", 8'(rx_cmd_count), 8'd0);
      // Polite host: each command consumed before the next
      for (int i = 0; i < 4; i++) begin
         host(2'h0);
         rx_cmd_pop = 1;
         tick();
         rx_cmd_pop = 0;
      end
      tick();
      check("count", 8'(rx_cmd_count), 8'd0);
      tick(5);
      stop_test();
   end
endmodule
bind ierr_reporter ierr_reporter_chk ierr_reporter_chk_inst (.clock, .rst, .rx_cmd_push,
   .rx_cmd_pop, .rx_parity_err, .rx_stop_bit_err, .servo_on_in, .fault_in, .rx_flush,
   .rx_cmd_discard, .error_reply_valid, .error_reply_code, .last_error_code,
   .common_error_display_code, .red_led, .caution_out, .fault_out, .servo_on_out,
   .rx_cmd_count);

//--- verilog/ierr_hold_timer.sv
// Retriggerable 2-second hold timer with LED flash phase
`timescale 1ns/100ps
module ierr_hold_timer
   import ierr_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic trigger,
   output logic      active,
   output logic      flash
);
   ierr_state_e       state_r;
   logic [HOLD_W-1:0] count_r;
   logic [HOLD_W-1:0] flash_cnt_r;

   // Each trigger restarts the full hold so the latest error extends it
   always_ff @(posedge clock) begin
      if (rst) begin
         state_r <= IERR_IDLE;
         count_r <= '0;
      end else if (trigger) begin
         state_r <= IERR_HOLD;
         count_r <= HOLD_W'(HOLD_CYCLES - 1);
      end else begin
         case (state_r)
            IERR_HOLD: begin
               if (count_r == '0) begin
                  state_r <= IERR_IDLE;
               end else begin
                  count_r <= count_r - 1'b1;
               end
            end
            default: state_r <= IERR_IDLE;
         endcase
      end
   end

   // Flash phase toggles every quarter second while holding
   always_ff @(posedge clock) begin
      if (rst || trigger) begin
         flash_cnt_r <= '0;
         flash       <= 1'b0;
      end else if (state_r == IERR_HOLD) begin
         if (flash_cnt_r == HOLD_W'(FLASH_CYCLES - 1)) begin
            flash_cnt_r <= '0;
            flash       <= ~flash;
         end else begin
            flash_cnt_r <= flash_cnt_r + 1'b1;
         end
      end else begin
         flash_cnt_r <= '0;
         flash       <= 1'b0;
      end
   end

   assign active = (state_r == IERR_HOLD);
endmodule

//--- verilog/ierr_pkg.sv
// Constants and types shared by the error reporting block
package ierr_pkg;
   // Clock and hold timing
   localparam int unsigned CLK_HZ        = 10000000;
   localparam int unsigned HOLD_TIME_MS  = 2000;
   localparam int unsigned HOLD_CYCLES   = (CLK_HZ / 1000) * HOLD_TIME_MS;
   localparam int unsigned HOLD_W        = 25;
   // LED flash half period
   localparam int unsigned FLASH_TIME_MS = 250;
   localparam int unsigned FLASH_CYCLES  = (CLK_HZ / 1000) * FLASH_TIME_MS;
   // Receive buffer depth in commands
   localparam int unsigned RXQ_DEPTH     = 100;
   localparam int unsigned RXQ_W         = 7;
   // Error codes, middle two hex digits of the Ex?E code
   localparam logic [7:0] ERR_NONE      = 8'h00;
   localparam logic [7:0] ERR_PGM_SAVE  = 8'h41;
   localparam logic [7:0] ERR_ZONE_SAVE = 8'h42;
   localparam logic [7:0] ERR_JOG_SAVE  = 8'h43;
   localparam logic [7:0] ERR_PGM_CANCEL= 8'h44;
   localparam logic [7:0] ERR_JOG_CANCEL= 8'h46;
   localparam logic [7:0] ERR_RX_OVF    = 8'h47;
   localparam logic [7:0] ERR_PARITY    = 8'h48;
   localparam logic [7:0] ERR_FRAMING   = 8'h49;
   // Power-up alarm bit positions
   localparam int unsigned ALM_19A = 0;
   localparam int unsigned ALM_1BA = 1;
   localparam int unsigned ALM_1FA = 2;
   localparam int unsigned ALM_22A = 3;
   // Table selector
   typedef enum logic [1:0] {IERR_TBL_PGM, IERR_TBL_ZONE, IERR_TBL_JOG, IERR_TBL_NONE} ierr_tbl_e;
   // Hold timer state
   typedef enum logic {IERR_IDLE, IERR_HOLD} ierr_state_e;
endpackage

//--- verilog/ierr_reporter.sv
// Error reporting unit: code capture, receive buffer count, timed indication
// How it works
// - Indication and warning held two seconds
// - Errors never touch servo power state
// - Show common error display code two seconds
// - Red LED flashes for two seconds
// - Alarm reply and fault output unchanged
// - Latest error code kept for query
// - Caution output active two seconds per error
// - Program table store failure gives E41E
// - Zone table store failure gives E42E
// - Jog table store failure gives E43E
// - Program start refused after power-up alarm 19A or 1BA
// - Jog start refused after power-up alarm 1FA or 22A
// - Buffer overflow gives E47E, buffer flushed
// - Parity error logs E48E, discards, no reply
// - Parity error still flags caution and LED
// - Stop bit error logs E49E, discards, flags
`timescale 1ns/100ps
module ierr_reporter
   import ierr_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             rst,
   // Non-volatile table write outcome
   input  wire logic             nv_write_fail,
   input  wire ierr_pkg::ierr_tbl_e nv_write_table,
   // Table operation start requests
   input  wire logic             program_table_start_req,
   input  wire logic             jog_table_start_req,
   // Power-up alarm flags, captured by the reporter
   input  wire logic [3:0]       powerup_alarms,
   input  wire logic             powerup_alarms_valid,
   // Serial receive side
   input  wire logic             rx_cmd_push,
   input  wire logic             rx_cmd_pop,
   input  wire logic             rx_parity_err,
   input  wire logic             rx_stop_bit_err,
   // Servo and fault state passed through untouched
   input  wire logic             servo_on_in,
   input  wire logic             fault_in,
   // Outputs
   output logic                  program_table_start_ok,
   output logic                  jog_table_start_ok,
   output logic                  rx_flush,
   output logic                  rx_cmd_discard,
   output logic                  error_reply_valid,
   output logic [7:0]            error_reply_code,
   output logic [7:0]            last_error_code,
   output logic                  common_error_display_code,
   output logic                  red_led,
   output logic                  caution_out,
   output logic                  fault_out,
   output logic                  servo_on_out,
   output logic [RXQ_W-1:0]      rx_cmd_count
);
   logic             pgm_blocked_r;
   logic             jog_blocked_r;
   logic             event_hit;
   logic [7:0]       event_code;
   logic             event_reply;
   logic             overflow;
   logic             hold_active;
   logic             hold_flash;
   logic [RXQ_W-1:0] rx_cmd_count_nxt;

   // Map a failed table write to its code
   function automatic logic [7:0] nv_fail_code(input ierr_tbl_e tbl);
      case (tbl)
         IERR_TBL_PGM:  nv_fail_code = ERR_PGM_SAVE;
         IERR_TBL_ZONE: nv_fail_code = ERR_ZONE_SAVE;
         IERR_TBL_JOG:  nv_fail_code = ERR_JOG_SAVE;
         default:       nv_fail_code = ERR_NONE;
      endcase
   endfunction

   // Power-up alarms accumulate on each valid strobe; later changes cannot unblock a start
   always_ff @(posedge clock) begin
      if (rst) begin
         pgm_blocked_r <= 1'b0;
         jog_blocked_r <= 1'b0;
      end else if (powerup_alarms_valid) begin
         pgm_blocked_r <= pgm_blocked_r | powerup_alarms[ALM_19A]
                          | powerup_alarms[ALM_1BA];
         jog_blocked_r <= jog_blocked_r | powerup_alarms[ALM_1FA]
                          | powerup_alarms[ALM_22A];
      end
   end

   // A push into a full buffer is an overflow
   assign overflow = rx_cmd_push && !rx_cmd_pop
                     && (rx_cmd_count == RXQ_W'(RXQ_DEPTH));

   // Event priority: later sources in this chain win if simultaneous
   always_comb begin
      event_hit   = 1'b0;
      event_code  = ERR_NONE;
      event_reply = 1'b0;
      if (nv_write_fail && nv_write_table != IERR_TBL_NONE) begin
         event_hit   = 1'b1;
         event_code  = nv_fail_code(nv_write_table);
         event_reply = 1'b1;
      end
      if (program_table_start_req && pgm_blocked_r) begin
         event_hit   = 1'b1;
         event_code  = ERR_PGM_CANCEL;
         event_reply = 1'b1;
      end
      if (jog_table_start_req && jog_blocked_r) begin
         event_hit   = 1'b1;
         event_code  = ERR_JOG_CANCEL;
         event_reply = 1'b1;
      end
      if (overflow) begin
         event_hit   = 1'b1;
         event_code  = ERR_RX_OVF;
         event_reply = 1'b1;
      end
      // Line errors send no reply, only indication
      if (rx_parity_err) begin
         event_hit   = 1'b1;
         event_code  = ERR_PARITY;
         event_reply = 1'b0;
      end
      if (rx_stop_bit_err) begin
         event_hit   = 1'b1;
         event_code  = ERR_FRAMING;
         event_reply = 1'b0;
      end
   end

   // Receive buffer occupancy; overflow empties it entirely
   always_comb begin
      rx_cmd_count_nxt = rx_cmd_count;
      if (overflow) begin
         rx_cmd_count_nxt = '0;
      end else if (rx_cmd_push && !rx_cmd_pop) begin
         rx_cmd_count_nxt = rx_cmd_count + 1'b1;
      end else if (rx_cmd_pop && !rx_cmd_push && rx_cmd_count != '0) begin
         rx_cmd_count_nxt = rx_cmd_count - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rx_cmd_count <= '0;
      end else begin
         rx_cmd_count <= rx_cmd_count_nxt;
      end
   end

   // Flush and discard strobes toward the receiver
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_flush       <= 1'b0;
         rx_cmd_discard <= 1'b0;
      end else begin
         rx_flush       <= overflow;
         rx_cmd_discard <= rx_parity_err | rx_stop_bit_err;
      end
   end

   // Most recent error code, kept until overwritten
   always_ff @(posedge clock) begin
      if (rst) begin
         last_error_code <= ERR_NONE;
      end else if (event_hit) begin
         last_error_code <= event_code;
      end
   end

   // Negative reply strobe toward the serial transmitter
   always_ff @(posedge clock) begin
      if (rst) begin
         error_reply_valid <= 1'b0;
         error_reply_code  <= ERR_NONE;
      end else begin
         error_reply_valid <= event_hit && event_reply;
         if (event_hit && event_reply) begin
            error_reply_code <= event_code;
         end
      end
   end

   // Start grants: refused while a power-up alarm blocks the table
   always_ff @(posedge clock) begin
      if (rst) begin
         program_table_start_ok <= 1'b0;
         jog_table_start_ok     <= 1'b0;
      end else begin
         program_table_start_ok <= program_table_start_req && !pgm_blocked_r;
         jog_table_start_ok     <= jog_table_start_req && !jog_blocked_r;
      end
   end

   // Shared hold timer for display, LED and caution
   ierr_hold_timer ierr_hold_timer_inst (
      .clock   (clock),
      .rst     (rst),
      .trigger (event_hit),
      .active  (hold_active),
      .flash   (hold_flash)
   );

   // Indication outputs registered; one cycle behind the timer
   always_ff @(posedge clock) begin
      if (rst) begin
         common_error_display_code <= 1'b0;
         red_led                   <= 1'b0;
         caution_out               <= 1'b0;
      end else begin
         common_error_display_code <= hold_active;
         red_led                   <= hold_active & ~hold_flash;
         caution_out               <= hold_active;
      end
   end

   // Servo power and fault pass through; errors never alter them
   always_ff @(posedge clock) begin
      if (rst) begin
         servo_on_out <= 1'b0;
         fault_out    <= 1'b0;
      end else begin
         servo_on_out <= servo_on_in;
         fault_out    <= fault_in;
      end
   end
endmodule
